// ### hdl/pbap_pkg.sv
`default_nettype none

package pbap_pkg;

	// ==========================================================
	// Register map (APB byte offsets)
	localparam int            PBAP_APB_ADDR_W = 8;
	localparam int            PBAP_NUM_PACR   = 5;
	localparam logic [7:0]    PBAP_OFF_MPR    = 8'h00;
	localparam logic [7:0]    PBAP_PACR_OFF [PBAP_NUM_PACR] = '{
		8'h20, 8'h24, 8'h28, 8'h2c, 8'h40
	};

	// ==========================================================
	// Slot geometry
	localparam int            PBAP_SLOT_LSB   = 12;
	localparam int            PBAP_SLOT_BITS  = 6;
	localparam int            PBAP_ADDR_W     = PBAP_SLOT_LSB + PBAP_SLOT_BITS;
	localparam int            PBAP_FIELDS_REG = 8;
	localparam int            PBAP_NUM_SLOTS  = PBAP_NUM_PACR * PBAP_FIELDS_REG;
	localparam int            PBAP_FIELD_W    = 4;
	localparam int            PBAP_ID_W       = 4;
	localparam int            PBAP_MPR_FIELDS = 8;

	// ==========================================================
	// Field bit positions within one 4-bit field
	localparam int            PBAP_BIT_RSVD        = 3;
	localparam int            PBAP_BIT_RD_TRUST    = 2;
	localparam int            PBAP_BIT_WR_TRUST    = 1;
	localparam int            PBAP_BIT_PRIV_PASS   = 0;
	localparam int            PBAP_BIT_SUPER_ONLY  = 2;
	localparam int            PBAP_BIT_WRITE_PROT  = 1;
	localparam int            PBAP_BIT_TRUST_ONLY  = 0;
	localparam logic [3:0]    PBAP_FIELD_MASK      = 4'h7;

	// ==========================================================
	// Integration defaults
	localparam logic [31:0]   PBAP_MPR_RESET   = 32'h0000_0000;
	localparam logic [31:0]   PBAP_PACR_RESET  = 32'h0000_0000;
	localparam logic [7:0]    PBAP_IMPL_MASTER = 8'h0d;
	localparam logic [39:0]   PBAP_IMPL_SLOTS  = 40'hff_ffff_ffff;

	// ==========================================================
	// Peripheral slot ownership, inclusive range
	localparam int            PBAP_NUM_PERIPH = 8;
	localparam logic [5:0]    PBAP_PERIPH_FIRST [PBAP_NUM_PERIPH] = '{
		6'h00, 6'h01, 6'h04, 6'h05, 6'h06, 6'h08, 6'h10, 6'h18
	};
	localparam logic [5:0]    PBAP_PERIPH_LAST [PBAP_NUM_PERIPH] = '{
		6'h00, 6'h03, 6'h04, 6'h05, 6'h07, 6'h0f, 6'h17, 6'h27
	};

	typedef enum logic [1:0] {
		PBAP_IDLE   = 2'b00,
		PBAP_CHECK  = 2'b01,
		PBAP_ACCESS = 2'b10,
		PBAP_REPLY  = 2'b11
	} pbap_state_type;

endpackage

`default_nettype wire

// ### hdl/pbap_access_check.sv
`timescale 1ns/1ps
`default_nettype none

module pbap_access_check
	import pbap_pkg::*;
(
	input  wire logic [3:0] prot,
	input  wire logic [3:0] priv,
	input  wire logic       is_write,
	input  wire logic       supervisor,
	output logic            eff_supervisor,
	output logic            super_fault,
	output logic            write_fault,
	output logic            trust_fault,
	output logic            deny
);

	// Privilege bit clear forces user mode
	assign eff_supervisor = supervisor & priv[PBAP_BIT_PRIV_PASS];
	assign super_fault    = prot[PBAP_BIT_SUPER_ONLY] & ~eff_supervisor;
	assign write_fault    = prot[PBAP_BIT_WRITE_PROT] & is_write;
	assign trust_fault    = prot[PBAP_BIT_TRUST_ONLY] & ~(is_write ?
		priv[PBAP_BIT_WR_TRUST] : priv[PBAP_BIT_RD_TRUST]);
	assign deny           = super_fault | write_fault | trust_fault;

endmodule

`default_nettype wire

// ### hdl/pbap_bridge.sv
`timescale 1ns/1ps
`default_nettype none

module pbap_bridge
	import pbap_pkg::*;
#(
	parameter logic [31:0] MPR_RESET_VALUE  = pbap_pkg::PBAP_MPR_RESET,
	parameter logic [31:0] PACR_RESET_VALUE = pbap_pkg::PBAP_PACR_RESET
)
(
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic [pbap_pkg::PBAP_APB_ADDR_W-1:0] paddr,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [31:0]                         pwdata,
	input  wire logic [3:0]                          pstrb,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                bm_req,
	input  wire logic [pbap_pkg::PBAP_ADDR_W-1:0]    bm_addr,
	input  wire logic                                bm_write,
	input  wire logic [31:0]                         bm_wdata,
	input  wire logic [pbap_pkg::PBAP_ID_W-1:0]      bm_master_id,
	input  wire logic                                bm_supervisor,
	output logic                                     bm_done,
	output logic                                     bm_error,
	output logic      [31:0]                         bm_rdata,
	output logic [pbap_pkg::PBAP_NUM_PERIPH-1:0]     per_sel,
	output logic [pbap_pkg::PBAP_ADDR_W-1:0]         per_addr,
	output logic                                     per_write,
	output logic      [31:0]                         per_wdata,
	output logic                                     per_supervisor,
	input  wire logic                                per_ready,
	input  wire logic [31:0]                         per_rdata,
	input  wire logic                                per_error
);
	import pbap_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [3:0] field_of(input logic [31:0] word,
		input logic [2:0] pos);
		return word[31 - 4 * int'(pos) -: 4];
	endfunction

	function automatic logic [31:0] nibble_mask(input logic [7:0] impl);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < PBAP_FIELDS_REG; i++) begin
			m[31 - 4 * i -: 4] = impl[i] ? PBAP_FIELD_MASK : 4'h0;
		end
		return m;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old & ~m) | (data & m);
	endfunction

	// Unimplemented or reserved bits stay zero
	localparam logic [31:0] MPR_MASK = nibble_mask(PBAP_IMPL_MASTER);

	function automatic logic [31:0] pacr_mask(input int r);
		return nibble_mask(PBAP_IMPL_SLOTS[8 * r +: 8]);
	endfunction

	// ==========================================================
	// Register file over APB
	logic [31:0] mpr_reg;
	logic [31:0] mpr_next;
	logic [31:0] pacr_reg  [PBAP_NUM_PACR];
	logic [31:0] pacr_next [PBAP_NUM_PACR];
	logic        pready_reg;
	logic        pready_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic        hit_mpr;
	logic [PBAP_NUM_PACR-1:0] hit_pacr;
	logic        apb_commit;
	logic [31:0] rd_word;

	always_comb begin
		hit_mpr  = (paddr == PBAP_OFF_MPR);
		rd_word  = hit_mpr ? mpr_reg : 32'h0000_0000;
		for (int r = 0; r < PBAP_NUM_PACR; r++) begin
			hit_pacr[r] = (paddr == PBAP_PACR_OFF[r]);
			if (hit_pacr[r]) begin
				rd_word = pacr_reg[r];
			end
		end
		apb_commit   = psel & penable & pready_reg;
		pready_next  = psel & penable & ~pready_reg;
		prdata_next  = pready_next ? rd_word : 32'h0000_0000;
		pslverr_next = pready_next & ~(hit_mpr | (|hit_pacr));
		mpr_next     = mpr_reg;
		if (apb_commit && pwrite && hit_mpr) begin
			mpr_next = merge(mpr_reg, pwdata, pstrb, MPR_MASK);
		end
		for (int r = 0; r < PBAP_NUM_PACR; r++) begin
			pacr_next[r] = pacr_reg[r];
			if (apb_commit && pwrite && hit_pacr[r]) begin
				pacr_next[r] = merge(pacr_reg[r], pwdata, pstrb,
					pacr_mask(r));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mpr_reg     <= MPR_RESET_VALUE & MPR_MASK;
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			for (int r = 0; r < PBAP_NUM_PACR; r++) begin
				pacr_reg[r] <= PACR_RESET_VALUE & pacr_mask(r);
			end
		end else begin
			mpr_reg     <= mpr_next;
			pready_reg  <= pready_next;
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
			for (int r = 0; r < PBAP_NUM_PACR; r++) begin
				pacr_reg[r] <= pacr_next[r];
			end
		end
	end

	assign pready  = pready_reg;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// ==========================================================
	// Access decode and protection
	pbap_state_type                state_reg;
	pbap_state_type                state_next;
	logic [PBAP_ADDR_W-1:0]        lat_addr_reg;
	logic [PBAP_ADDR_W-1:0]        lat_addr_next;
	logic                          lat_write_reg;
	logic                          lat_write_next;
	logic [31:0]                   lat_wdata_reg;
	logic [31:0]                   lat_wdata_next;
	logic [PBAP_ID_W-1:0]          lat_id_reg;
	logic [PBAP_ID_W-1:0]          lat_id_next;
	logic                          lat_sup_reg;
	logic                          lat_sup_next;
	logic [PBAP_SLOT_BITS-1:0]     slot;
	logic [3:0]                    slot_prot;
	logic [3:0]                    master_priv;
	logic [PBAP_NUM_PERIPH-1:0]    owner;
	logic                          eff_sup;
	logic                          super_fault;
	logic                          write_fault;
	logic                          trust_fault;
	logic                          deny;

	always_comb begin
		slot        = lat_addr_reg[PBAP_ADDR_W-1:PBAP_SLOT_LSB];
		slot_prot   = 4'h0;
		if (int'(slot) < PBAP_NUM_SLOTS) begin
			slot_prot = field_of(pacr_reg[slot[5:3]], slot[2:0]);
		end
		// IDs above the register's fields have no privileges
		master_priv = 4'h0;
		if (int'(lat_id_reg) < PBAP_MPR_FIELDS) begin
			master_priv = field_of(mpr_reg, lat_id_reg[2:0]);
		end
		for (int p = 0; p < PBAP_NUM_PERIPH; p++) begin
			owner[p] = (slot >= PBAP_PERIPH_FIRST[p]) &&
				(slot <= PBAP_PERIPH_LAST[p]);
		end
	end

	pbap_access_check u_check (
		.prot           (slot_prot),
		.priv           (master_priv),
		.is_write       (lat_write_reg),
		.supervisor     (lat_sup_reg),
		.eff_supervisor (eff_sup),
		.super_fault    (super_fault),
		.write_fault    (write_fault),
		.trust_fault    (trust_fault),
		.deny           (deny)
	);

	// ==========================================================
	// Transfer sequencer
	logic                       bm_done_reg;
	logic                       bm_done_next;
	logic                       bm_error_reg;
	logic                       bm_error_next;
	logic [31:0]                bm_rdata_reg;
	logic [31:0]                bm_rdata_next;
	logic [PBAP_NUM_PERIPH-1:0] per_sel_reg;
	logic [PBAP_NUM_PERIPH-1:0] per_sel_next;
	logic                       per_sup_reg;
	logic                       per_sup_next;

	always_comb begin
		state_next     = state_reg;
		lat_addr_next  = lat_addr_reg;
		lat_write_next = lat_write_reg;
		lat_wdata_next = lat_wdata_reg;
		lat_id_next    = lat_id_reg;
		lat_sup_next   = lat_sup_reg;
		bm_done_next   = 1'b0;
		bm_error_next  = bm_error_reg;
		bm_rdata_next  = bm_rdata_reg;
		per_sel_next   = per_sel_reg;
		per_sup_next   = per_sup_reg;
		unique case (state_reg)
			PBAP_IDLE: begin
				if (bm_req) begin
					lat_addr_next  = bm_addr;
					lat_write_next = bm_write;
					lat_wdata_next = bm_wdata;
					lat_id_next    = bm_master_id;
					lat_sup_next   = bm_supervisor;
					state_next     = PBAP_CHECK;
				end
			end
			PBAP_CHECK: begin
				if (deny || owner == '0) begin
					bm_done_next  = 1'b1;
					bm_error_next = 1'b1;
					bm_rdata_next = 32'h0000_0000;
					state_next    = PBAP_REPLY;
				end else begin
					per_sel_next = owner;
					per_sup_next = eff_sup;
					state_next   = PBAP_ACCESS;
				end
			end
			PBAP_ACCESS: begin
				if (per_ready) begin
					per_sel_next  = '0;
					bm_done_next  = 1'b1;
					bm_error_next = per_error;
					bm_rdata_next = lat_write_reg ? 32'h0000_0000 : per_rdata;
					state_next    = PBAP_REPLY;
				end
			end
			PBAP_REPLY: begin
				state_next = PBAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= PBAP_IDLE;
			lat_addr_reg  <= '0;
			lat_write_reg <= 1'b0;
			lat_wdata_reg <= 32'h0000_0000;
			lat_id_reg    <= '0;
			lat_sup_reg   <= 1'b0;
			bm_done_reg   <= 1'b0;
			bm_error_reg  <= 1'b0;
			bm_rdata_reg  <= 32'h0000_0000;
			per_sel_reg   <= '0;
			per_sup_reg   <= 1'b0;
		end else begin
			state_reg     <= state_next;
			lat_addr_reg  <= lat_addr_next;
			lat_write_reg <= lat_write_next;
			lat_wdata_reg <= lat_wdata_next;
			lat_id_reg    <= lat_id_next;
			lat_sup_reg   <= lat_sup_next;
			bm_done_reg   <= bm_done_next;
			bm_error_reg  <= bm_error_next;
			bm_rdata_reg  <= bm_rdata_next;
			per_sel_reg   <= per_sel_next;
			per_sup_reg   <= per_sup_next;
		end
	end

	assign bm_done        = bm_done_reg;
	assign bm_error       = bm_error_reg;
	assign bm_rdata       = bm_rdata_reg;
	assign per_sel        = per_sel_reg;
	assign per_addr       = lat_addr_reg;
	assign per_write      = lat_write_reg;
	assign per_wdata      = lat_wdata_reg;
	assign per_supervisor = per_sup_reg;

	// ==========================================================
	// Checks
	a_denied_no_access: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == PBAP_CHECK && super_fault
		|=> bm_done && bm_error && per_sel == '0 && state_reg == PBAP_REPLY
	) else $error("Supervisor fault did not end in error");

	a_write_prot_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == PBAP_CHECK && lat_write_reg &&
		slot_prot[PBAP_BIT_WRITE_PROT]
		|=> bm_error && bm_done ##1 state_reg == PBAP_IDLE && !bm_done
	) else $error("Write to protected slot was not refused");

	a_trust_prot_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == PBAP_CHECK && slot_prot[PBAP_BIT_TRUST_ONLY] &&
		!master_priv[lat_write_reg ? PBAP_BIT_WR_TRUST : PBAP_BIT_RD_TRUST]
		|=> bm_error && per_sel == '0
	) else $error("Untrusted master reached trust-only slot");

	a_route_owner: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == PBAP_CHECK && !deny && owner != '0
		|=> $onehot(per_sel) && per_sel == $past(owner) &&
			per_addr == $past(lat_addr_reg)
	) else $error("Slot routed to wrong peripheral");

	a_priv_forced: assert property (
		@(posedge pclk) disable iff (!presetn)
		per_sel != '0 |-> per_supervisor ==
			(lat_sup_reg & master_priv[PBAP_BIT_PRIV_PASS])
	) else $error("Privilege attribute not forced to user");

	a_field_reserved: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mpr_reg & ~MPR_MASK) == 32'h0000_0000 &&
		pacr_reg[0][31] == 1'b0 && pacr_reg[3][3] == 1'b0
	) else $error("Reserved or unimplemented bit set");

	a_pacr_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		apb_commit && pwrite && paddr == PBAP_PACR_OFF[1] && pstrb == 4'hf
		|=> pacr_reg[1] == ($past(pwdata) & pacr_mask(1))
	) else $error("Access-control write at 24 not stored");

	a_apb_answer: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable ##1 psel && penable
		|=> pready && pslverr == !(hit_mpr || hit_pacr != '0)
	) else $error("APB answer or error flag wrong");

	a_access_done: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == PBAP_ACCESS && per_ready
		|=> bm_done && per_sel == '0 && bm_error == $past(per_error)
	) else $error("Peripheral reply not returned to master");

endmodule

`default_nettype wire

// ### verif/pbap_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// Peripheral stand-in: answers after delay cycles
module pbap_periph_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  per_sel,
	input  wire logic [17:0] per_addr,
	input  wire logic        per_write,
	input  wire logic [31:0] per_wdata,
	input  wire logic        per_supervisor,
	input  wire logic [1:0]  delay,
	input  wire logic        err_cmd,
	output logic             per_ready,
	output logic [31:0]      per_rdata,
	output logic             per_error,
	output logic [31:0]      hits,
	output logic [7:0]       got_sel,
	output logic [31:0]      got_data,
	output logic             got_sup
);
	logic [1:0]  wait_reg;
	logic [31:0] noise_reg;

	assign per_ready = (|per_sel) && (wait_reg == delay);
	// Data bus never holds a stale value outside the answer
	assign per_rdata = per_ready ? {8'h5a, 6'h00, per_addr} : noise_reg;
	assign per_error = per_ready & err_cmd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_reg  <= 2'h0;
			noise_reg <= 32'h1234_5678;
			hits      <= 32'h0;
			got_sel   <= 8'h00;
			got_data  <= 32'h0;
			got_sup   <= 1'b0;
		end else begin
			noise_reg <= noise_reg + 32'h9e37_79b9;
			wait_reg  <= (|per_sel && !per_ready) ? wait_reg + 2'h1 : 2'h0;
			if (per_ready) begin
				hits     <= hits + 32'h1;
				got_sel  <= per_sel;
				got_data <= per_write ? per_wdata : {14'h0, per_addr};
				got_sup  <= per_supervisor;
			end
		end
	end
endmodule

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
	import pbap_pkg::*;
	localparam logic [31:0] MPR_MASK  = 32'h7077_0000;
	localparam logic [31:0] PACR_MASK = 32'h7777_7777;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, per_sel, got_sel;
	logic [31:0] pwdata, prdata, bm_wdata, bm_rdata, per_wdata, per_rdata;
	logic [31:0] hits, got_data, mpr_m;
	logic [31:0] pacr_m [5];
	logic [3:0]  pstrb, bm_master_id;
	logic [17:0] bm_addr, per_addr;
	logic        bm_req, bm_write, bm_supervisor, bm_done, bm_error;
	logic        per_write, per_supervisor, per_ready, per_error;
	logic        err_cmd, got_sup;
	logic [1:0]  delay;
	int          fail_count, cmp_count;

	pbap_bridge #(.MPR_RESET_VALUE(32'hffff_ffff),
		.PACR_RESET_VALUE(32'hffff_ffff)) DUT (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bm_req(bm_req),
		.bm_addr(bm_addr), .bm_write(bm_write), .bm_wdata(bm_wdata),
		.bm_master_id(bm_master_id), .bm_supervisor(bm_supervisor),
		.bm_done(bm_done), .bm_error(bm_error), .bm_rdata(bm_rdata),
		.per_sel(per_sel), .per_addr(per_addr), .per_write(per_write),
		.per_wdata(per_wdata), .per_supervisor(per_supervisor),
		.per_ready(per_ready), .per_rdata(per_rdata), .per_error(per_error));

	pbap_periph_model PER (.pclk(pclk), .presetn(presetn),
		.per_sel(per_sel), .per_addr(per_addr), .per_write(per_write),
		.per_wdata(per_wdata), .per_supervisor(per_supervisor),
		.delay(delay), .err_cmd(err_cmd), .per_ready(per_ready),
		.per_rdata(per_rdata), .per_error(per_error), .hits(hits),
		.got_sel(got_sel), .got_data(got_data), .got_sup(got_sup));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========
	// APB master: hold request until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			fail_count++;
			close_out();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
		input logic ex);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
		`CHK(r, x)
		`CHK(e, ex)
	endtask

	function automatic int owner(input logic [5:0] sl);
		for (int i = 0; i < PBAP_NUM_PERIPH; i++)
			if (sl >= PBAP_PERIPH_FIRST[i] && sl <= PBAP_PERIPH_LAST[i])
				return i;
		return -1;
	endfunction

	// ==========
	// Master access with expected verdict
	task automatic bm(input logic [17:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] id, input logic s);
		int          k, o;
		logic [31:0] h0;
		logic [5:0]  sl;
		logic [3:0]  f, p;
		logic        dn, ef;
		h0 = hits;
		sl = a[17:12];
		f = (id < 8) ? mpr_m[31 - 4 * id -: 4] : 4'h0;
		o = owner(sl);
		p = (o < 0) ? 4'h0 : pacr_m[sl / 8][31 - 4 * (sl % 8) -: 4];
		ef = s & f[0];
		dn = o < 0 || (p[2] && !ef) || (p[1] && w)
			|| (p[0] && !(w ? f[1] : f[2]));
		bm_req <= 1'b1;
		bm_addr <= a;
		bm_write <= w;
		bm_wdata <= d;
		bm_master_id <= id;
		bm_supervisor <= s;
		for (k = 0; k < 40; k++) begin
			@(posedge pclk);
			if (bm_done === 1'b1) break;
		end
		if (k == 40) begin
			fail_count++;
			close_out();
		end
		`CHK(bm_error, dn | err_cmd)
		`CHK(hits - h0, dn ? 32'h0 : 32'h1)
		if (dn) begin
			`CHK(bm_rdata, 32'h0)
		end else begin
			`CHK(got_sel, 8'h01 << o)
			`CHK(got_sup, ef)
			`CHK(got_data, w ? d : {14'h0, a})
			if (!w && !err_cmd) `CHK(bm_rdata, {8'h5a, 6'h00, a})
		end
		bm_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	initial begin
		int          i, j;
		logic [31:0] v, r;
		logic        e;
		logic [5:0]  sl;
		logic [7:0]  bad [4];
		logic [5:0]  corner [4];
		bad = '{8'h04, 8'h1c, 8'h30, 8'h44};
		corner = '{6'h03, 6'h04, 6'h27, 6'h28};
		{presetn, psel, penable, pwrite, bm_req, bm_write} = 6'h0;
		{bm_supervisor, err_cmd, delay} = 4'h0;
		{paddr, pwdata, pstrb, bm_addr, bm_wdata, bm_master_id} = '0;
		fail_count = 0;
		cmp_count = 0;
		void'($urandom(32'h5651));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(PBAP_OFF_MPR, MPR_MASK, 1'b0);
		for (i = 0; i < 5; i++)
			rdchk(PBAP_PACR_OFF[i], PACR_MASK, 1'b0);
		$display("test reset_values ends");
		for (i = 0; i < 12; i++) begin
			v = (i < 6) ? 32'hffff_ffff : $urandom;
			j = i % 6;
			if (j == 0) begin
				mpr_m = v;
				apb(1'b1, PBAP_OFF_MPR, v, 4'hf, r, e);
				rdchk(PBAP_OFF_MPR, v & MPR_MASK, 1'b0);
			end else begin
				apb(1'b1, PBAP_PACR_OFF[j - 1], v, 4'hf, r, e);
				rdchk(PBAP_PACR_OFF[j - 1], v & PACR_MASK, 1'b0);
			end
		end
		apb(1'b1, 8'h24, 32'h0, 4'hf, r, e);
		apb(1'b1, 8'h24, 32'hffff_ffff, 4'h5, r, e);
		rdchk(8'h24, 32'h0077_0077, 1'b0);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, bad[i], 32'hffff_ffff, 4'hf, r, e);
			`CHK(e, 1'b1)
			rdchk(bad[i], 32'h0, 1'b1);
		end
		rdchk(PBAP_OFF_MPR, mpr_m & MPR_MASK, 1'b0);
		$display("test registers ends");
		for (i = 0; i < 6; i++) begin
			mpr_m = (i == 0) ? 32'hffff_ffff : $urandom;
			apb(1'b1, PBAP_OFF_MPR, mpr_m, 4'hf, r, e);
			mpr_m = mpr_m & MPR_MASK;
			for (j = 0; j < 5; j++) begin
				pacr_m[j] = (i == 0) ? 32'h0 : $urandom;
				apb(1'b1, PBAP_PACR_OFF[j], pacr_m[j], 4'hf, r, e);
				pacr_m[j] = pacr_m[j] & PACR_MASK;
			end
			for (j = 0; j < 25; j++) begin
				delay <= 2'($urandom);
				err_cmd <= ($urandom % 8 == 0);
				sl = (j < 4) ? corner[j] : 6'($urandom % 48);
				bm({sl, 12'($urandom)}, 1'($urandom), $urandom,
					4'($urandom), 1'($urandom));
			end
		end
		$display("test accesses ends");
		close_out();
	end
endmodule

`default_nettype wire
